/* common/sgat_pkg.sv */
// Constants and types for the servo gain auto-tune controller
package sgat_pkg;
  localparam logic [15:0] SGAT_IDX_START    = 16'h2D50;
  localparam logic [15:0] SGAT_IDX_PROGRESS = 16'h2D51;
  localparam logic [15:0] SGAT_IDX_ABORT    = 16'h2D52;
  localparam logic [15:0] SGAT_IDX_RESTORE  = 16'h2D53;
  localparam logic [15:0] SGAT_IDX_RESULT   = 16'h2D54;
  localparam logic [7:0]  SGAT_START_RST    = 8'h00;
  localparam logic [7:0]  SGAT_MODE_BASIC   = 8'h01;
  localparam logic [7:0]  SGAT_MODE_HIGH    = 8'h02;
  localparam logic [7:0]  SGAT_MODE_LOW     = 8'h03;
  localparam logic [7:0]  SGAT_PROG_RST     = 8'h00;
  localparam logic [7:0]  SGAT_PROG_DONE    = 8'h64;
  localparam logic [15:0] SGAT_ABORT_KEY    = 16'h1EA5;
  localparam logic [15:0] SGAT_RESTORE_INIT = 16'h0000;
  localparam logic [15:0] SGAT_RESTORE_PREV = 16'h0001;
  localparam logic [15:0] SGAT_RES_OK       = 16'h0000;
  localparam logic [15:0] SGAT_RES_CANCEL   = 16'hC000;
  localparam logic [15:0] SGAT_RES_OVERSH   = 16'hC001;
  localparam logic [15:0] SGAT_RES_SRVOFF   = 16'hC002;
  localparam logic [15:0] SGAT_RES_CTLMODE  = 16'hC003;
  localparam logic [15:0] SGAT_RES_TIMEOUT  = 16'hC004;
  localparam logic [15:0] SGAT_RES_INERTIA  = 16'hC005;
  localparam logic [15:0] SGAT_RES_DISABLED = 16'hC00F;
  // Gain adjust select encodings
  localparam logic [1:0]  SGAT_GAIN_AUTO1   = 2'h1;
  localparam logic [1:0]  SGAT_GAIN_AUTO2   = 2'h2;
  localparam logic [1:0]  SGAT_GAIN_MANUAL  = 2'h3;
  localparam logic [15:0] SGAT_GAIN_INIT    = 16'h0000;
  localparam int          SGAT_CLK_HZ       = 50000000;
  localparam int          SGAT_CYCLE_MAX_S  = 30;
  localparam int          SGAT_SAVE_MIN     = 60;
  localparam longint      SGAT_CYCLE_CYC    =
    longint'(SGAT_CYCLE_MAX_S) * SGAT_CLK_HZ;
  localparam longint      SGAT_SAVE_CYC     =
    longint'(SGAT_SAVE_MIN) * 60 * SGAT_CLK_HZ;
  typedef enum logic [2:0] {
    SGAT_IDLE = 3'h1,
    SGAT_RUN  = 3'h2,
    SGAT_DONE = 3'h4
  } sgat_state_t;
endpackage

/* hw/sgat_ctrl.sv */
// Servo gain auto-tune controller: object access, one-shot run, auto tune
`timescale 1ns/1ps
module sgat_ctrl
  import sgat_pkg::*;
#(
  parameter longint CYCLE_LIMIT = SGAT_CYCLE_CYC,
  parameter longint SAVE_PERIOD = SGAT_SAVE_CYC
) (
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic        obj_wr,
  input  wire logic [15:0] obj_index,
  input  wire logic [15:0] obj_wdata,
  output logic      [15:0] obj_rdata,
  input  wire logic        motor_accel,
  input  wire logic        torque_mode,
  input  wire logic        servo_on,
  input  wire logic        alarm,
  input  wire logic        tune_enable,
  input  wire logic        tune_step,
  input  wire logic        cycle_tick,
  input  wire logic [6:0]  tune_progress,
  input  wire logic        tune_finish,
  input  wire logic [15:0] tune_status,
  input  wire logic [15:0] tuned_gain,
  input  wire logic [15:0] inertia_estimate,
  input  wire logic [15:0] nvm_gain,
  input  wire logic [15:0] nvm_inertia,
  input  wire logic [1:0]  gain_adjust_select_param,
  input  wire logic [4:0]  response_level_param,
  output logic [15:0]      inertia_ratio_param,
  output logic [15:0]      model_loop_gain_param,
  output logic [15:0]      gain_table_index,
  input  wire logic [15:0] table_gain,
  output logic [1:0]       tune_mode,
  output logic             tune_run,
  output logic             nvm_save
);
  sgat_state_t state_r;
  logic [7:0]  start_r;
  logic [7:0]  prog_r;
  logic [15:0] result_r;
  logic [15:0] prev_gain_r;
  logic [31:0] cyc_cnt_r;
  logic [39:0] save_cnt_r;
  logic [1:0]  sel_r;
  logic [1:0]  sel_s1_r;
  logic [1:0]  sel_s2_r;
  logic        booted_r;
  logic        wr_start;
  logic        wr_abort;
  logic        wr_restore;
  logic        restore_ok;
  logic        kill;

  // Object decode
  always_comb begin
    wr_start   = 1'b0;
    wr_abort   = 1'b0;
    wr_restore = 1'b0;
    if (obj_wr && obj_index == SGAT_IDX_START) begin
      wr_start = 1'b1;
    end else if (obj_wr && obj_index == SGAT_IDX_ABORT) begin
      wr_abort = 1'b1;
    end else if (obj_wr && obj_index == SGAT_IDX_RESTORE) begin
      wr_restore = 1'b1;
    end
  end

  // Registered read data, one clock behind the index
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      obj_rdata <= 16'h0000;
    end else if (obj_index == SGAT_IDX_START) begin
      obj_rdata <= {8'h00, start_r};
    end else if (obj_index == SGAT_IDX_PROGRESS) begin
      obj_rdata <= {8'h00, prog_r};
    end else if (obj_index == SGAT_IDX_RESULT) begin
      obj_rdata <= result_r;
    end else begin
      obj_rdata <= 16'h0000;
    end
  end

  assign restore_ok = wr_restore && state_r != SGAT_RUN &&
    (obj_wdata == SGAT_RESTORE_INIT || obj_wdata == SGAT_RESTORE_PREV);
  assign kill = (wr_abort && obj_wdata == SGAT_ABORT_KEY) || alarm ||
    cyc_cnt_r >= 32'(CYCLE_LIMIT);

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state_r  <= SGAT_IDLE;
      start_r  <= SGAT_START_RST;
      prog_r   <= SGAT_PROG_RST;
      result_r <= SGAT_RES_OK;
    end else begin
      case (state_r)
        SGAT_IDLE: begin
          if (wr_start && obj_wdata >= 16'(SGAT_MODE_BASIC) &&
              obj_wdata <= 16'(SGAT_MODE_LOW)) begin
            prog_r <= SGAT_PROG_DONE;
            if (!tune_enable) begin
              result_r <= SGAT_RES_DISABLED;
            end else if (torque_mode) begin
              result_r <= SGAT_RES_CTLMODE;
            end else if (!servo_on) begin
              result_r <= SGAT_RES_SRVOFF;
            end else begin
              start_r  <= obj_wdata[7:0];
              prog_r   <= SGAT_PROG_RST;
              result_r <= SGAT_RES_OK;
              state_r  <= SGAT_RUN;
            end
          end
        end
        SGAT_RUN: begin
          prog_r <= {1'b0, tune_progress};
          if (kill) begin
            if (alarm || (wr_abort && obj_wdata == SGAT_ABORT_KEY)) begin
              result_r <= SGAT_RES_CANCEL;
            end else begin
              result_r <= SGAT_RES_TIMEOUT;
            end
            state_r <= SGAT_DONE;
          end else if (tune_finish) begin
            result_r <= tune_status;
            state_r  <= SGAT_DONE;
          end
        end
        SGAT_DONE: begin
          start_r <= SGAT_START_RST;
          prog_r  <= SGAT_PROG_DONE;
          state_r <= SGAT_IDLE;
        end
        default: state_r <= SGAT_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n || state_r != SGAT_RUN || cycle_tick) begin
      cyc_cnt_r <= 32'h00000000;
    end else begin
      cyc_cnt_r <= cyc_cnt_r + 32'h00000001;
    end
  end

  // Mode select sampled three times, it comes from the parameter store
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      sel_s1_r <= SGAT_GAIN_AUTO1;
      sel_s2_r <= SGAT_GAIN_AUTO1;
      sel_r    <= SGAT_GAIN_AUTO1;
    end else begin
      sel_s1_r <= gain_adjust_select_param;
      sel_s2_r <= sel_s1_r;
      sel_r    <= sel_s2_r;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n || save_cnt_r >= 40'(SAVE_PERIOD - 1)) begin
      save_cnt_r <= 40'h0000000000;
    end else begin
      save_cnt_r <= save_cnt_r + 40'h0000000001;
    end
  end

  // Parameter set; gains in one register kept simple on purpose
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      booted_r              <= 1'b0;
      inertia_ratio_param   <= SGAT_GAIN_INIT;
      model_loop_gain_param <= SGAT_GAIN_INIT;
      prev_gain_r           <= SGAT_GAIN_INIT;
    end else if (!booted_r) begin
      booted_r              <= 1'b1;
      inertia_ratio_param   <= nvm_inertia;
      model_loop_gain_param <= nvm_gain;
    end else if (restore_ok) begin
      if (obj_wdata == SGAT_RESTORE_INIT) begin
        model_loop_gain_param <= SGAT_GAIN_INIT;
      end else begin
        model_loop_gain_param <= prev_gain_r;
      end
    end else if (state_r == SGAT_IDLE && wr_start &&
                 tune_enable && !torque_mode && servo_on &&
                 obj_wdata >= 16'(SGAT_MODE_BASIC) &&
                 obj_wdata <= 16'(SGAT_MODE_LOW)) begin
      prev_gain_r <= model_loop_gain_param;
    end else if (state_r == SGAT_RUN && !kill && tune_finish &&
                 tune_status == SGAT_RES_OK) begin
      model_loop_gain_param <= tuned_gain;
    end else if (state_r == SGAT_IDLE && sel_r != SGAT_GAIN_MANUAL &&
                 tune_step) begin
      if (sel_r == SGAT_GAIN_AUTO1 && motor_accel) begin
        inertia_ratio_param <= inertia_estimate;
      end
      model_loop_gain_param <= table_gain;
    end
  end

  // Table index from inertia and response level
  // Registered, so table data lags an inertia change by a clock
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      gain_table_index <= 16'h0000;
    end else begin
      gain_table_index <= {inertia_ratio_param[10:0], response_level_param};
    end
  end
  assign tune_mode = start_r[1:0];
  assign tune_run  = state_r == SGAT_RUN;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      nvm_save <= 1'b0;
    end else begin
      nvm_save <= restore_ok || save_cnt_r >= 40'(SAVE_PERIOD - 1) ||
        (sel_r != SGAT_GAIN_MANUAL && sel_s2_r == SGAT_GAIN_MANUAL);
    end
  end

  property p_done_clear;
    @(posedge sys_clk) disable iff (!rst_n)
      state_r == SGAT_DONE |=> start_r == SGAT_START_RST &&
        prog_r == SGAT_PROG_DONE;
  endproperty
  a_done_clear: assert property (p_done_clear)
    else $error("start object not cleared after run");

  property p_abort;
    @(posedge sys_clk) disable iff (!rst_n)
      state_r == SGAT_RUN && wr_abort && obj_wdata == SGAT_ABORT_KEY
      |=> state_r == SGAT_DONE ##1 result_r == SGAT_RES_CANCEL;
  endproperty
  a_abort: assert property (p_abort)
    else $error("abort key did not stop run");

  property p_torque;
    @(posedge sys_clk) disable iff (!rst_n)
      state_r == SGAT_IDLE && wr_start && tune_enable && torque_mode &&
      obj_wdata >= 16'(SGAT_MODE_BASIC) &&
      obj_wdata <= 16'(SGAT_MODE_LOW)
      |=> state_r == SGAT_IDLE && result_r == SGAT_RES_CTLMODE;
  endproperty
  a_torque: assert property (p_torque)
    else $error("torque mode start not refused");

  property p_alarm;
    @(posedge sys_clk) disable iff (!rst_n)
      state_r == SGAT_RUN && alarm |=> state_r == SGAT_DONE;
  endproperty
  a_alarm: assert property (p_alarm)
    else $error("alarm did not end run");

  property p_save_restore;
    @(posedge sys_clk) disable iff (!rst_n)
      restore_ok |=> nvm_save;
  endproperty
  a_save_restore: assert property (p_save_restore)
    else $error("restore not saved");

  property p_start;
    @(posedge sys_clk) disable iff (!rst_n)
      state_r == SGAT_IDLE && wr_start && tune_enable && !torque_mode &&
      servo_on && obj_wdata == 16'(SGAT_MODE_LOW)
      |=> tune_run && start_r == SGAT_MODE_LOW;
  endproperty
  a_start: assert property (p_start)
    else $error("valid start did not launch run");

  property p_no_restart;
    @(posedge sys_clk) disable iff (!rst_n)
      state_r == SGAT_RUN && !kill && !tune_finish |=> $stable(start_r);
  endproperty
  a_no_restart: assert property (p_no_restart)
    else $error("start changed during run");

  property p_finish_gain;
    @(posedge sys_clk) disable iff (!rst_n)
      state_r == SGAT_RUN && !kill && tune_finish && !restore_ok &&
      tune_status == SGAT_RES_OK && booted_r
      |=> model_loop_gain_param == $past(tuned_gain);
  endproperty
  a_finish_gain: assert property (p_finish_gain)
    else $error("tuned gain not committed");

  property p_prog_done;
    @(posedge sys_clk) disable iff (!rst_n)
      state_r == SGAT_DONE |=> ##1 prog_r == SGAT_PROG_DONE ||
        state_r == SGAT_RUN;
  endproperty
  a_prog_done: assert property (p_prog_done)
    else $error("progress not 100 at end");

  property p_refuse_code;
    @(posedge sys_clk) disable iff (!rst_n)
      state_r == SGAT_IDLE && wr_start && !tune_enable &&
      obj_wdata == 16'(SGAT_MODE_BASIC)
      |=> state_r == SGAT_IDLE && result_r == SGAT_RES_DISABLED;
  endproperty
  a_refuse_code: assert property (p_refuse_code)
    else $error("disabled start not refused");

  property p_timeout;
    @(posedge sys_clk) disable iff (!rst_n)
      state_r == SGAT_RUN && !alarm && !wr_abort &&
      cyc_cnt_r >= 32'(CYCLE_LIMIT)
      |=> state_r == SGAT_DONE && result_r == SGAT_RES_TIMEOUT;
  endproperty
  a_timeout: assert property (p_timeout)
    else $error("stalled cycle did not time out");

  property p_bad_key;
    @(posedge sys_clk) disable iff (!rst_n)
      state_r == SGAT_RUN && wr_abort && obj_wdata != SGAT_ABORT_KEY &&
      !alarm && !tune_finish && cyc_cnt_r < 32'(CYCLE_LIMIT)
      |=> state_r == SGAT_RUN;
  endproperty
  a_bad_key: assert property (p_bad_key)
    else $error("wrong abort key stopped run");

  property p_restore_init;
    @(posedge sys_clk) disable iff (!rst_n)
      restore_ok && booted_r && obj_wdata == SGAT_RESTORE_INIT
      |=> model_loop_gain_param == SGAT_GAIN_INIT;
  endproperty
  a_restore_init: assert property (p_restore_init)
    else $error("restore did not reload initial gain");

  property p_auto2_hold;
    @(posedge sys_clk) disable iff (!rst_n)
      booted_r && sel_r != SGAT_GAIN_AUTO1 |=> $stable(inertia_ratio_param);
  endproperty
  a_auto2_hold: assert property (p_auto2_hold)
    else $error("inertia changed outside mode 1");

  property p_manual_save;
    @(posedge sys_clk) disable iff (!rst_n)
      sel_r == SGAT_GAIN_AUTO2 && sel_s2_r == SGAT_GAIN_MANUAL |=> nvm_save;
  endproperty
  a_manual_save: assert property (p_manual_save)
    else $error("mode change to manual not saved");
endmodule

/* bench/sgat_host.sv */
// Controller model: object writes and reads toward the tune controller
`timescale 1ns/1ps
module sgat_host
  import sgat_pkg::*;
(
  input  wire logic        sys_clk,
  output logic             obj_wr,
  output logic [15:0]      obj_index,
  output logic [15:0]      obj_wdata,
  input  wire logic [15:0] obj_rdata
);
  initial begin
    obj_wr    = 1'b0;
    obj_index = SGAT_IDX_START;
    obj_wdata = 16'h0000;
  end
  // Data inverted after the strobe, so stale values are never trusted
  task automatic wr(input logic [15:0] idx, input logic [15:0] dat);
    @(posedge sys_clk);
    #1;
    obj_wr    = 1'b1;
    obj_index = idx;
    obj_wdata = dat;
    @(posedge sys_clk);
    #1;
    obj_wr    = 1'b0;
    obj_wdata = ~dat;
  endtask
  // Object read, one clock after the index
  task automatic rd(input logic [15:0] idx, output logic [15:0] dat);
    @(posedge sys_clk);
    #1;
    obj_index = idx;
    @(posedge sys_clk);
    #1;
    dat = obj_rdata;
  endtask
endmodule

/* bench/tb_servo_gain_autotune_control.sv */
// Testbench for the servo gain auto-tune controller
`timescale 1ns/1ps
module tb_servo_gain_autotune_control
  import sgat_pkg::*;
;
  logic        sys_clk          = 1'b0;
  logic        rst_n            = 1'b0;
  logic        motor_accel      = 1'b0;
  logic        torque_mode      = 1'b0;
  logic        servo_on         = 1'b1;
  logic        alarm            = 1'b0;
  logic        tune_enable      = 1'b1;
  logic        tune_step        = 1'b0;
  logic        cycle_tick       = 1'b1;
  logic [6:0]  tune_progress    = 7'h00;
  logic        tune_finish      = 1'b0;
  logic [15:0] tune_status      = 16'h0000;
  logic [15:0] tuned_gain       = 16'h0000;
  logic [15:0] inertia_estimate = 16'h0000;
  logic [15:0] nvm_gain         = 16'h0A5A;
  logic [15:0] nvm_inertia      = 16'h0033;
  logic [1:0]  gain_sel         = SGAT_GAIN_AUTO1;
  logic [4:0]  resp             = 5'h07;
  logic [15:0] table_gain       = 16'h0456;
  logic        obj_wr;
  logic [15:0] obj_index, obj_wdata, obj_rdata, inertia_ratio_param;
  logic [15:0] model_loop_gain_param, gain_table_index;
  logic [1:0]  tune_mode;
  logic        tune_run, nvm_save;
  int          num_errors       = 0;
  int          cmp_count        = 0;
  int          saves            = 0;
  logic [15:0] err_code [5]     = '{SGAT_RES_CTLMODE, SGAT_RES_DISABLED,
                                    SGAT_RES_SRVOFF, SGAT_RES_CANCEL,
                                    SGAT_RES_TIMEOUT};

  initial begin
    forever #10 sys_clk = ~sys_clk;
  end

  // Short counts keep the watchdog and periodic save reachable
  sgat_ctrl #(.CYCLE_LIMIT(50), .SAVE_PERIOD(100)) DUT (
    .sys_clk, .rst_n, .obj_wr, .obj_index, .obj_wdata, .obj_rdata,
    .motor_accel, .torque_mode, .servo_on, .alarm, .tune_enable,
    .tune_step, .cycle_tick, .tune_progress, .tune_finish, .tune_status,
    .tuned_gain, .inertia_estimate, .nvm_gain, .nvm_inertia,
    .gain_adjust_select_param(gain_sel), .response_level_param(resp),
    .inertia_ratio_param, .model_loop_gain_param, .gain_table_index,
    .table_gain, .tune_mode, .tune_run, .nvm_save
  );

  sgat_host host (
    .sys_clk, .obj_wr, .obj_index, .obj_wdata, .obj_rdata
  );

  always @(posedge sys_clk) begin
    if (rst_n === 1'b1 && nvm_save === 1'b1) begin
      saves <= saves + 1;
    end
  end

  task automatic complete_run();
    $display("counts: %0d compares, %0d mismatches", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp,
                     input string what);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic chk_obj(input logic [15:0] idx, input logic [15:0] exp);
    logic [15:0] v;
    host.rd(idx, v);
    chk(v, exp, "object read");
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  // Bounded wait; a hang counts an error instead of stalling the run
  task automatic wait_idle();
    int k;
    k = 0;
    while (tune_run !== 1'b0 && k < 200) begin
      @(posedge sys_clk);
      #1;
      k++;
    end
    if (k == 200) begin
      num_errors++;
      $display("wrong value at %0t: run never ended", $time);
    end
    cyc(2);
  endtask

  task automatic pulse_step();
    repeat (2) begin
      tune_step = 1'b1;
      cyc(1);
      tune_step = 1'b0;
      cyc(2);
    end
  endtask

  initial begin
    #2000000;
    num_errors++;
    $display("wrong value at %0t: global timeout", $time);
    complete_run();
  end

  initial begin
    cyc(5);
    rst_n = 1'b1;
    cyc(2);
    chk(model_loop_gain_param, 16'h0A5A, "power-on gain");
    chk(inertia_ratio_param, 16'h0033, "power-on inertia");
    chk_obj(SGAT_IDX_START, 16'h0000);
    chk_obj(SGAT_IDX_PROGRESS, 16'h0000);
    chk_obj(SGAT_IDX_RESULT, 16'h0000);
    chk_obj(SGAT_IDX_ABORT, 16'h0000);
    chk_obj(16'h2D55, 16'h0000);
    cyc(240);
    chk(16'(saves), 16'h0002, "periodic saves");
    $display("test reset and periodic save done");
    for (int m = 1; m <= 3; m++) begin
      tuned_gain = 16'h1100 + 16'(m);
      tune_progress = 7'h28;
      host.wr(SGAT_IDX_START, 16'(m));
      cyc(2);
      chk({14'h0, tune_mode}, 16'(m), "run mode");
      chk_obj(SGAT_IDX_START, 16'(m));
      chk_obj(SGAT_IDX_PROGRESS, 16'h0028);
      tune_status = SGAT_RES_OK;
      tune_finish = 1'b1;
      cyc(1);
      tune_finish = 1'b0;
      wait_idle();
      chk_obj(SGAT_IDX_START, 16'h0000);
      chk_obj(SGAT_IDX_PROGRESS, 16'h0064);
      chk_obj(SGAT_IDX_RESULT, SGAT_RES_OK);
      chk(model_loop_gain_param, tuned_gain, "tuned gain");
    end
    $display("test three response modes done");
    host.wr(SGAT_IDX_RESTORE, SGAT_RESTORE_PREV);
    chk({15'h0, nvm_save}, 16'h0001, "restore commit");
    cyc(3);
    chk(model_loop_gain_param, 16'h1102, "restore prev");
    host.wr(SGAT_IDX_RESTORE, SGAT_RESTORE_INIT);
    cyc(3);
    chk(model_loop_gain_param, SGAT_GAIN_INIT, "restore init");
    $display("test restore done");
    host.wr(SGAT_IDX_START, 16'h0004);
    cyc(2);
    chk({15'h0, tune_run}, 16'h0000, "bad mode ignored");
    host.wr(SGAT_IDX_START, 16'h0002);
    host.wr(SGAT_IDX_START, 16'h0003);
    host.wr(SGAT_IDX_ABORT, 16'h1EA4);
    cyc(2);
    chk_obj(SGAT_IDX_START, 16'h0002);
    chk({15'h0, tune_run}, 16'h0001, "run held");
    host.wr(SGAT_IDX_ABORT, SGAT_ABORT_KEY);
    wait_idle();
    chk_obj(SGAT_IDX_RESULT, SGAT_RES_CANCEL);
    chk_obj(SGAT_IDX_PROGRESS, 16'h0064);
    chk(model_loop_gain_param, SGAT_GAIN_INIT, "gain kept");
    $display("test ignored writes and abort done");
    for (int i = 0; i < 5; i++) begin
      torque_mode = (i == 0);
      tune_enable = (i != 1);
      servo_on = (i != 2);
      cycle_tick = (i != 4);
      host.wr(SGAT_IDX_START, 16'h0001);
      cyc(3);
      alarm = (i == 3);
      wait_idle();
      chk_obj(SGAT_IDX_RESULT, err_code[i]);
      chk_obj(SGAT_IDX_PROGRESS, 16'h0064);
      chk_obj(SGAT_IDX_START, 16'h0000);
      alarm = 1'b0;
    end
    cycle_tick = 1'b1;
    tuned_gain = 16'h0F0F;
    host.wr(SGAT_IDX_START, 16'h0002);
    cyc(2);
    tune_status = SGAT_RES_INERTIA;
    tune_finish = 1'b1;
    cyc(1);
    tune_finish = 1'b0;
    wait_idle();
    chk_obj(SGAT_IDX_RESULT, SGAT_RES_INERTIA);
    chk_obj(SGAT_IDX_PROGRESS, 16'h0064);
    chk(model_loop_gain_param, SGAT_GAIN_INIT, "failed gain");
    $display("test failure codes done");
    inertia_estimate = 16'h0123;
    motor_accel = 1'b1;
    pulse_step();
    chk(inertia_ratio_param, 16'h0123, "estimate");
    chk(gain_table_index, {11'h123, 5'h07}, "table index");
    chk(model_loop_gain_param, 16'h0456, "auto1 gain");
    gain_sel = SGAT_GAIN_AUTO2;
    cyc(5);
    inertia_estimate = 16'h0200;
    table_gain = 16'h0789;
    pulse_step();
    chk(inertia_ratio_param, 16'h0123, "inertia held");
    chk(model_loop_gain_param, 16'h0789, "auto2 gain");
    gain_sel = SGAT_GAIN_MANUAL;
    cyc(3);
    chk({15'h0, nvm_save}, 16'h0001, "manual save");
    cyc(5);
    $display("test auto tuning modes done");
    complete_run();
  end
endmodule
